// ---- rtl/hss_ctrl_map.svh ----
// Overview of operation
// - Enable low: sleep, high side output and low gate drive off.
// - In sleep the fault status line stays released high.
// - Enable rising: normal mode, inputs ignored during the blanking interval.
// - Blanking interval nominally 25 us, within 10 to 50 us.
// - Cross-conduction config low: both switches follow their inputs independently.
// - Config high: never both on; high side input wins.
// - Config high: low gate rises only after high gate falls below 2 V.
// - Fault status pulled low while any fault is detected.
// - Under-voltage turns high side off until supply recovers with hysteresis.
// - Under-voltage clears latched faults and reports in real time.
// - Over-temperature monitored in every output state.
// - High side over-temperature turns output off until cooled, repeatedly.
// - Low gate driver over-temperature turns both outputs off until cooled.
// - Fault release after over-temperature delayed by the blanking interval.
// - Any over-temperature forces temperature feedback output to zero.
// - Over-temperature fault self-clears; over-current and overload stay latched.
// - High side over-current turns output off, latches, zeroes current sense.
// - Over-current clears after high input held low for reset time.
// - Latched over-current drives current sense high once input is low.
// - Fault reset time nominally 200 us, within 100 to 400 us.
// - Low side overload detection armed only while low input high.
// - Low overload latches, gate off, threshold current source disabled.
// - Low overload clears after low input held low for reset time.
`ifndef HSS_CTRL_MAP_SVH
`define HSS_CTRL_MAP_SVH

`define CLK_PERIOD_NS      10
`define BLANK_TIME_US      25
`define BLANK_CYCLES       ((`BLANK_TIME_US * 1000) / `CLK_PERIOD_NS)
`define FAULT_RESET_US     200
`define FAULT_RESET_CYCLES ((`FAULT_RESET_US * 1000) / `CLK_PERIOD_NS)
`define CNT_WIDTH          16

`endif

// ---- rtl/hss_ctrl_pkg.sv ----
package hss_ctrl_pkg;
    typedef enum logic [1:0] {
        SLEEP,
        BLANK,
        NORMAL
    } mode_t;

    typedef struct packed {
        logic enable;
        logic hsIn;
        logic lsIn;
        logic xcondCfg;
    } ctrl_in_t;

    typedef struct packed {
        logic supplyUnder;
        logic supplyRecovered;
        logic hsOverTemp;
        logic lsOverTemp;
        logic hsOverCurrent;
        logic lowDrainOver;
        logic hsGateBelow2v;
    } sense_in_t;
endpackage

// ---- rtl/interval_timer.sv ----
`timescale 1ns/1ps
// counts while run is high; done once count reaches limit
module interval_timer #(
    parameter int WIDTH = 16
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic             run,
    input  wire logic [WIDTH-1:0] limit,
    output logic                  done
);
    logic [WIDTH-1:0] count;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            count <= '0;
        end else if (!run) begin
            count <= '0;
        end else if (count != limit) begin
            count <= count + 1'b1;
        end
    end

    assign done = run && (count == limit);
endmodule

// ---- rtl/fault_latch.sv ----
`timescale 1ns/1ps
`include "hss_ctrl_map.svh"
// latches on trip, clears after releaseLow held high for hold cycles
module fault_latch #(
    parameter int HOLD_CYCLES = `FAULT_RESET_CYCLES
) (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic trip,
    input  wire logic releaseLow,
    input  wire logic forceClear,
    output logic      latched
);
    logic holdDone;

    interval_timer #(.WIDTH(`CNT_WIDTH)) holdTimer (
        .core_clk (core_clk),
        .reset    (reset),
        .run      (latched && releaseLow),
        .limit    (`CNT_WIDTH'(HOLD_CYCLES)),
        .done     (holdDone)
    );

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            latched <= 1'b0;
        end else if (trip) begin
            latched <= 1'b1;
        end else if (forceClear || holdDone) begin
            latched <= 1'b0;
        end
    end
endmodule

// ---- rtl/hss_ctrl.sv ----
`timescale 1ns/1ps
`include "hss_ctrl_map.svh"
module hss_ctrl
    import hss_ctrl_pkg::*;
#(
    parameter int BLANK_CYCLES = `BLANK_CYCLES,
    parameter int RESET_CYCLES = `FAULT_RESET_CYCLES
) (
    input  wire logic      core_clk,
    input  wire logic      reset,
    input  wire ctrl_in_t  ctrl,
    input  wire sense_in_t sense,
    output logic           highSideOn,
    output logic           low_gate_drive,
    output logic           fault_status_n_oe,
    output logic           tempFeedbackZero,
    output logic           current_sense_low,
    output logic           current_sense_high,
    output logic           lowThresholdSourceOn,
    output logic           bootstrapChargeOn
);
    mode_t mode;
    logic  blankDone;
    logic  uvActive;
    logic  otActive;
    logic  otWasActive;
    logic  otReleaseRun;
    logic  otReleaseDone;
    logic  ocLatched;
    logic  lsLatched;
    logic  ocTrip;
    logic  lsTrip;
    logic  hsCmd;
    logic  lsCmd;
    logic  next_highSideOn;
    logic  next_lowGate;
    logic  awake;

    // mode sequencing
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mode <= SLEEP;
        end else if (!ctrl.enable) begin
            mode <= SLEEP;
        end else begin
            case (mode)
                SLEEP:   mode <= BLANK;
                BLANK:   if (blankDone) mode <= NORMAL;
                NORMAL:  mode <= NORMAL;
                default: mode <= SLEEP;
            endcase
        end
    end

    interval_timer #(.WIDTH(`CNT_WIDTH)) blankTimer (
        .core_clk (core_clk),
        .reset    (reset),
        .run      (mode == BLANK && ctrl.enable),
        .limit    (`CNT_WIDTH'(BLANK_CYCLES)),
        .done     (blankDone)
    );

    assign awake = (mode != SLEEP);

    // under-voltage with hysteresis
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            uvActive <= 1'b0;
        end else if (sense.supplyUnder) begin
            uvActive <= 1'b1;
        end else if (sense.supplyRecovered) begin
            uvActive <= 1'b0;
        end
    end

    assign otActive = sense.hsOverTemp || sense.lsOverTemp;

    // over-temperature release delay
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            otWasActive <= 1'b0;
        end else if (!awake) begin
            otWasActive <= 1'b0;
        end else if (otActive) begin
            otWasActive <= 1'b1;
        end else if (otReleaseDone) begin
            otWasActive <= 1'b0;
        end
    end

    assign otReleaseRun = otWasActive && !otActive;

    interval_timer #(.WIDTH(`CNT_WIDTH)) otTimer (
        .core_clk (core_clk),
        .reset    (reset),
        .run      (otReleaseRun),
        .limit    (`CNT_WIDTH'(BLANK_CYCLES)),
        .done     (otReleaseDone)
    );

    assign ocTrip = awake && sense.hsOverCurrent && highSideOn;
    assign lsTrip = awake && ctrl.lsIn && sense.lowDrainOver;

    fault_latch #(.HOLD_CYCLES(RESET_CYCLES)) ocFault (
        .core_clk   (core_clk),
        .reset      (reset),
        .trip       (ocTrip),
        .releaseLow (!ctrl.hsIn),
        .forceClear (sense.supplyUnder || !awake),
        .latched    (ocLatched)
    );

    fault_latch #(.HOLD_CYCLES(RESET_CYCLES)) lsFault (
        .core_clk   (core_clk),
        .reset      (reset),
        .trip       (lsTrip),
        .releaseLow (!ctrl.lsIn),
        .forceClear (sense.supplyUnder || !awake),
        .latched    (lsLatched)
    );

    // command gating and cross-conduction
    always_comb begin
        hsCmd = (mode == NORMAL) && ctrl.hsIn;
        lsCmd = (mode == NORMAL) && ctrl.lsIn;
        next_highSideOn = hsCmd && !uvActive && !otActive
                          && !ocLatched && !ocTrip;
        if (ctrl.xcondCfg) begin
            // high side wins; low waits for gate below 2 V
            next_lowGate = lsCmd && !hsCmd && !highSideOn
                           && sense.hsGateBelow2v;
        end else begin
            next_lowGate = lsCmd;
        end
        if (sense.lsOverTemp || lsLatched || lsTrip) begin
            next_lowGate = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            highSideOn     <= 1'b0;
            low_gate_drive <= 1'b0;
        end else begin
            highSideOn     <= next_highSideOn;
            low_gate_drive <= next_lowGate;
        end
    end

    // status outputs
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            fault_status_n_oe    <= 1'b0;
            tempFeedbackZero     <= 1'b0;
            current_sense_low    <= 1'b0;
            current_sense_high   <= 1'b0;
            lowThresholdSourceOn <= 1'b0;
            bootstrapChargeOn    <= 1'b0;
        end else begin
            fault_status_n_oe    <= awake && (uvActive || otActive
                                    || otWasActive || ocLatched
                                    || lsLatched);
            tempFeedbackZero     <= awake && otActive;
            current_sense_low    <= awake && ocLatched
                                    && ctrl.hsIn;
            current_sense_high   <= awake && ocLatched
                                    && !ctrl.hsIn;
            lowThresholdSourceOn <= awake && !lsLatched;
            bootstrapChargeOn    <= awake;
        end
    end
endmodule

// ---- tb/hss_ctrl_props.sv ----
`timescale 1ns/1ps
module hss_ctrl_props
    import hss_ctrl_pkg::*;
#(
    parameter int BLANK_CYCLES = 8,
    parameter int RESET_CYCLES = 16
) (
    input  wire logic      core_clk,
    input  wire logic      reset,
    input  wire ctrl_in_t  ctrl,
    input  wire sense_in_t sense,
    input  wire logic      highSideOn,
    input  wire logic      low_gate_drive,
    input  wire logic      fault_status_n_oe,
    input  wire logic      tempFeedbackZero,
    input  wire logic      lowThresholdSourceOn
);
    logic hot;
    assign hot = sense.hsOverTemp || sense.lsOverTemp;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    a_sleep_off: assert property (
        !ctrl.enable [*3] |-> !highSideOn && !low_gate_drive)
        else $error("output on while asleep");
    a_sleep_quiet: assert property (
        (!ctrl.enable && !sense.supplyUnder) [*3] |-> !fault_status_n_oe)
        else $error("fault line pulled while asleep");
    a_blank_ignore: assert property (
        $rose(ctrl.enable) |=> !highSideOn [*8])
        else $error("high side on during blanking");
    a_xcond_excl: assert property (
        ctrl.xcondCfg [*2] |-> !(highSideOn && low_gate_drive))
        else $error("both switches on");
    a_gate_wait: assert property (
        ctrl.xcondCfg && !sense.hsGateBelow2v |=> !low_gate_drive)
        else $error("low gate before high gate discharged");
    a_oc_trip: assert property (
        ctrl.enable [*2] ##0 (sense.hsOverCurrent && highSideOn)
        |=> !highSideOn ##1 fault_status_n_oe)
        else $error("over-current not acted on");
    a_ot_shut: assert property (
        ctrl.enable [*2] ##0 hot
        |=> tempFeedbackZero && !highSideOn && fault_status_n_oe)
        else $error("over-temperature not acted on");
    a_ls_hot: assert property (
        ctrl.enable && sense.lsOverTemp |=> !low_gate_drive)
        else $error("low gate on while driver hot");
    a_ls_trip: assert property (
        ctrl.enable [*2] ##0 (ctrl.lsIn && sense.lowDrainOver)
        |=> !low_gate_drive ##1 !lowThresholdSourceOn)
        else $error("low side overload not acted on");
    a_uv_shut: assert property (
        ctrl.enable [*2] ##0 sense.supplyUnder
        |=> ##1 (!highSideOn && fault_status_n_oe))
        else $error("under-voltage not acted on");
    a_ot_hold: assert property (
        ctrl.enable [*2] ##0 $fell(hot)
        |=> (fault_status_n_oe || !ctrl.enable) [*8])
        else $error("fault released early after cooling");
endmodule
bind hss_ctrl hss_ctrl_props #(
    .BLANK_CYCLES(BLANK_CYCLES),
    .RESET_CYCLES(RESET_CYCLES)
) props (
    .core_clk, .reset, .ctrl, .sense, .highSideOn, .low_gate_drive,
    .fault_status_n_oe, .tempFeedbackZero, .lowThresholdSourceOn
);

// ---- tb/hss_host_model.sv ----
`timescale 1ns/1ps
module hss_host_model (
    input  wire logic core_clk,
    input  wire logic highSideOn,
    input  wire logic fault_status_n_oe,
    output logic      faultLine,
    output logic      gateBelow2v
);
    logic [2:0] gateOff = 3'h7;
    // pull-up resistor on the open-drain status line
    assign faultLine = !fault_status_n_oe;
    // gate discharges a few cycles after turn-off
    always_ff @(posedge core_clk) begin
        gateOff <= {gateOff[1:0], !highSideOn};
    end
    assign gateBelow2v = &gateOff;
endmodule

// ---- tb/hss_ctrl_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fails++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module hss_ctrl_tb_top
    import hss_ctrl_pkg::*;
();
    localparam int BLANK = 8;
    localparam int HOLD  = 16;
    logic      core_clk = 1'b0;
    logic      reset = 1'b1;
    ctrl_in_t  ctrl = '0;
    sense_in_t sense = '0;
    logic      faultLine, gateBelow2v, highSideOn, low_gate_drive;
    logic      fault_status_n_oe, tempFeedbackZero, current_sense_low;
    logic      current_sense_high, lowThresholdSourceOn, bootstrapChargeOn;
    logic [6:0] outs;
    int        fails = 0;
    int        checked = 0;
    assign outs = {highSideOn, low_gate_drive, faultLine, tempFeedbackZero,
        lowThresholdSourceOn, current_sense_low, current_sense_high};
    always #5 core_clk = ~core_clk;
    hss_ctrl #(.BLANK_CYCLES(BLANK), .RESET_CYCLES(HOLD)) dut (
        .core_clk(core_clk), .reset(reset), .ctrl(ctrl),
        .sense({sense[6:1], gateBelow2v}), .highSideOn(highSideOn),
        .low_gate_drive(low_gate_drive), .fault_status_n_oe(fault_status_n_oe),
        .tempFeedbackZero(tempFeedbackZero),
        .current_sense_low(current_sense_low),
        .current_sense_high(current_sense_high),
        .lowThresholdSourceOn(lowThresholdSourceOn),
        .bootstrapChargeOn(bootstrapChargeOn));
    hss_host_model host (.core_clk(core_clk), .highSideOn(highSideOn),
        .fault_status_n_oe(fault_status_n_oe), .faultLine(faultLine),
        .gateBelow2v(gateBelow2v));
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic print_verdict;
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        step(16);
        reset = 1'b0;
        ctrl = 4'h6;
        step(3);
        `CHK({outs, bootstrapChargeOn}, 8'h20)
        ctrl = 4'he;
        step(3);
        `CHK(outs[6:4], 3'h1)
        step(BLANK + 2);
        `CHK({outs, bootstrapChargeOn}, 8'he9)
        for (int i = 0; i < 8; i++) begin
            ctrl = {1'b1, i[2:0]};
            step(7);
            `CHK(outs, {i[2], i[1] & ~(i[0] & i[2]), 5'h14})
        end
        ctrl = 4'hb;
        step(2);
        `CHK(low_gate_drive, 1'b0)
        step(5);
        `CHK(low_gate_drive, 1'b1)
        ctrl = 4'hc;
        step(2);
        `CHK(highSideOn, 1'b1)
        sense = 7'h04;
        step(1);
        sense = 7'h00;
        step(3);
        `CHK(outs, 7'h06)
        ctrl = 4'h8;
        step(HOLD / 2);
        `CHK(outs, 7'h05)
        ctrl = 4'hc;
        step(3);
        `CHK(outs[6:4], 3'h0)
        ctrl = 4'h8;
        step(HOLD + 3);
        `CHK(outs, 7'h14)
        sense = 7'h02;
        step(3);
        `CHK(outs, 7'h14)
        ctrl = 4'ha;
        step(3);
        sense = 7'h00;
        `CHK(outs, 7'h00)
        ctrl = 4'h8;
        step(HOLD + 3);
        ctrl = 4'ha;
        step(3);
        `CHK(outs, 7'h34)
        ctrl = 4'he;
        sense = 7'h10;
        step(3);
        `CHK(outs, 7'h2c)
        sense = 7'h00;
        step(3);
        `CHK(faultLine, 1'b0)
        step(BLANK + 2);
        `CHK(outs, 7'h74)
        sense = 7'h08;
        step(3);
        `CHK(outs, 7'h0c)
        sense = 7'h00;
        step(BLANK + 5);
        `CHK(outs, 7'h74)
        sense = 7'h04;
        step(1);
        sense = 7'h40;
        step(3);
        `CHK(outs[6:4], 3'h2)
        sense = 7'h00;
        step(3);
        `CHK(highSideOn, 1'b0)
        sense = 7'h20;
        step(1);
        sense = 7'h00;
        step(3);
        `CHK(outs, 7'h74)
        ctrl = 4'h6;
        sense = 7'h10;
        step(3);
        `CHK({outs[6:4], bootstrapChargeOn}, 4'h2)
        print_verdict();
    end
endmodule
